// File: gpl_params.svh
`ifndef GPL_PARAMS_SVH
`define GPL_PARAMS_SVH

// Register byte offsets inside the block window
`define GPL_OFF_LED       12'h1BC
`define GPL_OFF_INTSE     12'h1E8
`define GPL_OFF_TOP_STS   12'h058
`define GPL_OFF_TOP_EN    12'h05C

// Field positions
`define GPL_STS_LSB       0
`define GPL_EN_LSB        16
`define GPL_SUM_BIT       12
`define GPL_TOP_EN_BIT    12
`define GPL_SEL_LSB       0
`define GPL_FUNC_LSB      8

// Reset values
`define GPL_STS_RST       12'h000
`define GPL_EN_RST        12'h000
`define GPL_SEL_RST       8'h00
`define GPL_FUNC_RST      2'h0

// Timing: least level width and the clock rate
`define GPL_CLK_MHZ       10
`define GPL_FILT_NS       40
`define GPL_FILT_CYC      (((`GPL_FILT_NS * `GPL_CLK_MHZ) + 999) / 1000)

`endif

// File: gpl_pkg.sv
`default_nettype none
package gpl_pkg;

   // Bus slave phase, Gray ordered
   typedef enum logic [0:0] {
      GPL_AHB_IDLE = 1'b0,
      GPL_AHB_DATA = 1'b1
   } gpl_ahb_st_t;

   // LED behaviour code
   typedef logic [1:0] gpl_led_fun_t;

endpackage
`default_nettype wire

// File: gpl_lvl_filt.sv
`default_nettype none
module gpl_lvl_filt #(
   parameter int CYC = 1
) (
   input  wire logic sys_clk,   // System clock
   input  wire logic rst_n,     // Synchronised reset, active low
   input  wire logic lvl_in,    // Raw source level
   output logic      lvl_out    // Qualified level
);
   localparam int CNT_W = $clog2(CYC + 1);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             lvl_r;

   // Count consecutive active samples, saturating
   always_comb begin
      cnt_nxt = '0;
      if (lvl_in) begin
         cnt_nxt = (cnt_r >= CNT_W'(CYC)) ? cnt_r : cnt_r + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         lvl_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         lvl_r <= lvl_in && (cnt_nxt >= CNT_W'(CYC));
      end
   end

   assign lvl_out = lvl_r;

   AST_FILT_DROP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !lvl_in |=> !lvl_out)
      else $error("filter passed an inactive level");

endmodule
`default_nettype wire

// File: gpl_ahb_if.sv
`default_nettype none
module gpl_ahb_if (
   input  wire logic        sys_clk,    // System clock
   input  wire logic        rst_n,      // Synchronised reset, active low
   input  wire logic        hsel,       // Slave select
   input  wire logic [31:0] haddr,      // Address
   input  wire logic [1:0]  htrans,     // Transfer type
   input  wire logic        hwrite,     // Write when high
   input  wire logic        hready,     // Bus ready
   input  wire logic [31:0] rdata,      // Read value from register file
   output logic             wr_stb,     // Write strobe in data phase
   output logic             rd_stb,     // Read strobe in data phase
   output logic [11:0]      acc_addr,   // Captured offset
   output logic             hreadyout,  // Slave ready
   output logic             hresp,      // Response, always OKAY
   output logic [31:0]      hrdata      // Read data
);
   import gpl_pkg::*;

   gpl_ahb_st_t st_r;
   logic [11:0] addr_r;
   logic        write_r;
   logic        rdy_r;
   logic [31:0] rdata_r;
   logic        accept;

   // Address phase taken only from an active transfer
   assign accept = hsel && htrans[1] && hready;

   // Phase tracking, one wait state per transfer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r    <= GPL_AHB_IDLE;
         addr_r  <= 12'h000;
         write_r <= 1'b0;
         rdy_r   <= 1'b1;
      end else if (accept) begin
         st_r    <= GPL_AHB_DATA;
         addr_r  <= haddr[11:0];
         write_r <= hwrite;
         rdy_r   <= 1'b0;
      end else if (st_r == GPL_AHB_DATA) begin
         st_r  <= GPL_AHB_IDLE;
         rdy_r <= 1'b1;
      end
   end

   // Read data registered at the end of the wait state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd_stb) begin
         rdata_r <= rdata;
      end
   end

   assign wr_stb    = (st_r == GPL_AHB_DATA) && write_r;
   assign rd_stb    = (st_r == GPL_AHB_DATA) && !write_r;
   assign acc_addr  = addr_r;
   assign hreadyout = rdy_r;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_r;

endmodule
`default_nettype wire

// File: gpl_gpio_irq_led.sv
`default_nettype none
`include "gpl_params.svh"
module gpl_gpio_irq_led #(
   parameter int PINS     = 12,
   parameter int LED_PINS = 8,
   parameter int FILT_CYC = `GPL_FILT_CYC
) (
   input  wire logic                 sys_clk,            // System clock, 10 MHz
   input  wire logic                 rstn,               // Power-on reset, active low
   input  wire logic                 hsel,               // AHB select
   input  wire logic [31:0]          haddr,              // AHB address
   input  wire logic [1:0]           htrans,             // AHB transfer type
   input  wire logic                 hwrite,             // AHB write
   input  wire logic [2:0]           hsize,              // AHB size, words only
   input  wire logic [31:0]          hwdata,             // AHB write data
   input  wire logic                 hready,             // AHB ready
   output logic                      hreadyout,          // AHB slave ready
   output logic                      hresp,              // AHB response
   output logic [31:0]               hrdata,             // AHB read data
   input  wire logic [PINS-1:0]      pin_irq_src,        // Pin event levels
   input  wire logic                 external_reset_n,   // External reset pin
   input  wire gpl_pkg::gpl_led_fun_t led_function_strap, // LED function strap
   input  wire logic [LED_PINS-1:0]  led_select_strap,   // LED select strap
   input  wire logic                 eep_ld_valid,       // EEPROM loader write
   input  wire gpl_pkg::gpl_led_fun_t eep_ld_func,       // Loader LED function
   input  wire logic [LED_PINS-1:0]  eep_ld_sel,         // Loader LED select
   input  wire logic [LED_PINS-1:0]  gpio_dout,          // General purpose drive
   input  wire logic [LED_PINS-1:0]  led_drive,          // LED engine drive
   output logic [LED_PINS-1:0]       pin_out,            // Muxed pin drive
   output logic [LED_PINS-1:0]       pin_led_sel,        // Pin in LED mode
   output gpl_pkg::gpl_led_fun_t     led_func,           // LED function code
   output logic                      host_irq            // Host interrupt level
);
   import gpl_pkg::*;

   logic                rst_meta_r;
   logic                rst_n;
   logic [PINS-1:0]     filt;
   logic [PINS-1:0]     sts_r;
   logic [PINS-1:0]     sts_nxt;
   logic [PINS-1:0]     en_r;
   logic                top_en_r;
   logic                sum_r;
   logic                irq_r;
   logic [LED_PINS-1:0] led_sel_r;
   gpl_led_fun_t        led_func_r;
   logic [LED_PINS-1:0] pin_out_r;
   logic                strap_pend_r;
   logic                strap_ld;
   logic                wr_stb;
   logic                rd_stb;
   logic [11:0]         acc_addr;
   logic [31:0]         rdata;
   logic                wr_intse;
   logic                wr_led;
   logic                wr_top_en;
   logic                any_en;

   // Reset release through two flip-flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Bus slave front end
   gpl_ahb_if u_ahb (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .rdata     (rdata),
      .wr_stb    (wr_stb),
      .rd_stb    (rd_stb),
      .acc_addr  (acc_addr),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata)
   );

   // Per-pin level qualification
   for (genvar i = 0; i < PINS; i++) begin : g_filt
      gpl_lvl_filt #(
         .CYC (FILT_CYC)
      ) u_filt (
         .sys_clk (sys_clk),
         .rst_n   (rst_n),
         .lvl_in  (pin_irq_src[i]),
         .lvl_out (filt[i])
      );
   end

   always_comb begin
      wr_intse  = 1'b0;
      wr_led    = 1'b0;
      wr_top_en = 1'b0;
      if (!wr_stb) begin
         wr_intse = 1'b0;
      end else if (acc_addr == `GPL_OFF_INTSE) begin
         wr_intse = 1'b1;
      end else if (acc_addr == `GPL_OFF_LED) begin
         wr_led = 1'b1;
      end else if (acc_addr == `GPL_OFF_TOP_EN) begin
         wr_top_en = 1'b1;
      end
   end

   // read mux, reserved and unmapped read as zero
   always_comb begin
      rdata = 32'h0000_0000;
      if (acc_addr == `GPL_OFF_INTSE) begin
         rdata[`GPL_STS_LSB +: PINS] = sts_r;
         rdata[`GPL_EN_LSB +: PINS]  = en_r;
      end else if (acc_addr == `GPL_OFF_LED) begin
         rdata[`GPL_SEL_LSB +: LED_PINS] = led_sel_r;
         rdata[`GPL_FUNC_LSB +: 2]       = led_func_r;
      end else if (acc_addr == `GPL_OFF_TOP_STS) begin
         rdata[`GPL_SUM_BIT] = sum_r;
      end else if (acc_addr == `GPL_OFF_TOP_EN) begin
         rdata[`GPL_TOP_EN_BIT] = top_en_r;
      end
   end

   // write one clears, a new event in the same cycle wins
   always_comb begin
      sts_nxt = sts_r;
      if (wr_intse) begin
         sts_nxt = sts_r & ~hwdata[`GPL_STS_LSB +: PINS];
      end
      sts_nxt = sts_nxt | filt;
   end

   // Sticky pin status
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sts_r <= `GPL_STS_RST;
      end else begin
         sts_r <= sts_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_r <= `GPL_EN_RST;
      end else if (wr_intse) begin
         en_r <= hwdata[`GPL_EN_LSB +: PINS];
      end
   end

   // Top-level general purpose interrupt enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         top_en_r <= 1'b0;
      end else if (wr_top_en) begin
         top_en_r <= hwdata[`GPL_TOP_EN_BIT];
      end
   end

   assign any_en = |(sts_r & en_r);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sum_r <= 1'b0;
      end else begin
         sum_r <= any_en;
      end
   end

   // host interrupt gated by top-level enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= any_en && top_en_r;
      end
   end

   // straps pending from reset until the external reset is high
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_pend_r <= 1'b1;
      end else if (!external_reset_n) begin
         strap_pend_r <= 1'b1;
      end else begin
         strap_pend_r <= 1'b0;
      end
   end

   assign strap_ld = strap_pend_r && external_reset_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         led_sel_r  <= `GPL_SEL_RST;
         led_func_r <= `GPL_FUNC_RST;
      end else if (strap_ld) begin
         led_sel_r  <= led_select_strap;
         led_func_r <= led_function_strap;
      end else if (eep_ld_valid) begin
         led_sel_r  <= eep_ld_sel;
         led_func_r <= eep_ld_func;
      end else if (wr_led) begin
         led_sel_r  <= hwdata[`GPL_SEL_LSB +: LED_PINS];
         led_func_r <= gpl_led_fun_t'(hwdata[`GPL_FUNC_LSB +: 2]);
      end
   end

   // LED function reaches only selected pins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_r <= '0;
      end else begin
         pin_out_r <= (led_sel_r & led_drive) | (~led_sel_r & gpio_dout);
      end
   end

   assign pin_out     = pin_out_r;
   assign pin_led_sel = led_sel_r;
   assign led_func    = led_func_r;
   assign host_irq    = irq_r;

   // Checks on this block's own logic
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_ext_rel;
      !external_reset_n ##1 external_reset_n;
   endsequence

   sequence s_rd_intse;
      rd_stb && (acc_addr == `GPL_OFF_INTSE);
   endsequence

   sequence s_accept;
      hsel && htrans[1] && hready;
   endsequence

   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   AST_STS_CLEAR: assert property (
      wr_intse && hwdata[`GPL_STS_LSB] && !filt[0] |=> !sts_r[0])
      else $error("status bit not cleared by write of one");

   AST_STS_KEEP: assert property (
      wr_intse && !hwdata[`GPL_STS_LSB] && sts_r[0] |=> sts_r[0])
      else $error("status bit lost on write of zero");

   AST_SET_WINS: assert property (
      wr_intse && ((hwdata[`GPL_STS_LSB +: PINS] & filt) != '0) |=>
         ((sts_r & $past(filt)) == $past(filt)))
      else $error("clear won over a new event");

   AST_SUMMARY: assert property (
      ##1 sum_r == $past(|(sts_r & en_r)))
      else $error("summary bit does not match enabled status");

   AST_EN_WRITE: assert property (
      wr_intse |=> en_r == $past(hwdata[`GPL_EN_LSB +: PINS]))
      else $error("enable bits not written");

   AST_EN_HOLD: assert property (
      !wr_intse |=> $stable(en_r))
      else $error("enable bits changed without a write");

   AST_CAPTURE: assert property (
      (filt != '0) |=> ((sts_r & $past(filt)) == $past(filt)))
      else $error("event not captured in status");

   AST_IRQ: assert property (
      host_irq |-> $past(top_en_r) && $past(|(sts_r & en_r)))
      else $error("interrupt without enabled source");

   AST_IRQ_SET: assert property (
      top_en_r && (sts_r[0] && en_r[0]) |=> host_irq)
      else $error("enabled source did not raise interrupt");

   AST_TOP_GATE: assert property (
      !top_en_r |=> !host_irq)
      else $error("interrupt raised with top enable clear");

   AST_LED_MUX: assert property (
      led_sel_r[0] |=> pin_out[0] == $past(led_drive[0]))
      else $error("selected pin does not carry LED drive");

   AST_GP_PIN: assert property (
      !led_sel_r[0] |=> pin_out[0] == $past(gpio_dout[0]))
      else $error("unselected pin affected by LED logic");

   AST_FUNC_WR: assert property (
      wr_led && !strap_ld && !eep_ld_valid |=>
         led_func_r == $past(hwdata[`GPL_FUNC_LSB +: 2]))
      else $error("LED function not written");

   AST_STRAP: assert property (
      s_ext_rel |=> (led_sel_r == $past(led_select_strap)) &&
                    (led_func_r == $past(led_function_strap)))
      else $error("straps not latched at reset release");

   AST_EEP: assert property (
      eep_ld_valid && !strap_ld |=> led_sel_r == $past(eep_ld_sel))
      else $error("loader value not applied");

   AST_LED_HOLD: assert property (
      !strap_ld && !eep_ld_valid && !wr_led |=> $stable(led_sel_r) && $stable(led_func_r))
      else $error("LED fields changed without a source");

   AST_LED_READ: assert property (
      rd_stb && (acc_addr == `GPL_OFF_LED) |=>
         hrdata == {22'h00_0000, $past(led_func_r), $past(led_sel_r)})
      else $error("LED configuration read wrong");

   AST_INTSE_READ: assert property (
      s_rd_intse |=> hrdata == {4'h0, $past(en_r), 4'h0, $past(sts_r)})
      else $error("status enable read wrong");

   AST_BUS_WAIT: assert property (
      s_accept |=> s_one_wait)
      else $error("bus answer not after one wait state");

   AST_RSV: assert property (
      s_rd_intse |=> (hrdata[31:28] == 4'h0) && (hrdata[15:12] == 4'h0))
      else $error("reserved bits not zero");

endmodule
`default_nettype wire

// File: gpl_pin_model.sv
`default_nettype none
module gpl_pin_model #(
   parameter int HOLD = 2
) (
   input  wire logic        sys_clk,      // System clock
   input  wire logic [11:0] ev_req,       // One-cycle event request per pin
   output var logic  [11:0] pin_irq_src,  // Event levels seen by the block
   output var logic  [7:0]  gpio_dout,    // General purpose drive pattern
   output var logic  [7:0]  led_drive     // LED engine drive pattern
);
   timeunit 1ns;
   timeprecision 1ns;

   int hold_cnt = 0;

   // Fixed, distinct drive patterns so the pin mux choice is visible
   assign gpio_dout = 8'h3c;
   assign led_drive = 8'ha5;

   always @(posedge sys_clk) begin
      if (ev_req != 12'h000) begin
         pin_irq_src <= ev_req;
         hold_cnt    <= HOLD;
      end else if (hold_cnt > 1) begin
         hold_cnt <= hold_cnt - 1;
      end else begin
         pin_irq_src <= 12'h000;
         hold_cnt    <= 0;
      end
   end
endmodule
`default_nettype wire

// File: tb_top.sv
`default_nettype none
`include "gpl_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import gpl_pkg::*;

   logic          sys_clk          = 1'b0;
   logic          rstn             = 1'b0;
   logic          hsel             = 1'b0;
   logic [31:0]   haddr            = 32'h0000_0000;
   logic [1:0]    htrans           = 2'h0;
   logic          hwrite           = 1'b0;
   logic [2:0]    hsize            = 3'h2;
   logic [31:0]   hwdata           = 32'h0000_0000;
   logic          hready;
   logic          hreadyout;
   logic          hresp;
   logic [31:0]   hrdata;
   logic [11:0]   ev_req           = 12'h000;
   logic [11:0]   pin_irq_src;
   logic          external_reset_n = 1'b1;
   gpl_led_fun_t  fun_strap        = 2'h2;
   logic [7:0]    sel_strap        = 8'h5a;
   logic          eep_ld_valid     = 1'b0;
   gpl_led_fun_t  eep_ld_func      = 2'h0;
   logic [7:0]    eep_ld_sel       = 8'h00;
   logic [7:0]    gpio_dout;
   logic [7:0]    led_drive;
   logic [7:0]    pin_out;
   logic [7:0]    pin_led_sel;
   gpl_led_fun_t  led_func;
   logic          host_irq;
   int            bad_count        = 0;
   int            compares         = 0;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;

   // Clock, 100 ns period
   always #50 sys_clk = ~sys_clk;

   gpl_gpio_irq_led dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_irq_src(pin_irq_src),
      .external_reset_n(external_reset_n), .led_function_strap(fun_strap),
      .led_select_strap(sel_strap), .eep_ld_valid(eep_ld_valid), .eep_ld_func(eep_ld_func),
      .eep_ld_sel(eep_ld_sel), .gpio_dout(gpio_dout), .led_drive(led_drive),
      .pin_out(pin_out), .pin_led_sel(pin_led_sel), .led_func(led_func), .host_irq(host_irq)
   );

   gpl_pin_model model_u (
      .sys_clk(sys_clk), .ev_req(ev_req), .pin_irq_src(pin_irq_src),
      .gpio_dout(gpio_dout), .led_drive(led_drive)
   );

   // Compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One single-word transfer; waits on ready in both phases
   task automatic ahb_xfer(input logic wr, input logic [11:0] off, input logic [31:0] wd,
                           output logic [31:0] rd);
      int n;
      n = 0;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {20'h0_0000, off};
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      rd = hrdata;
      check("bus response", {31'h0, hresp}, 32'h0000_0000);
      if (n >= 100) begin
         bad_count++;
      end
   endtask

   task automatic reg_wr(input logic [11:0] off, input logic [31:0] wd);
      logic [31:0] junk;
      ahb_xfer(1'b1, off, wd, junk);
   endtask

   task automatic reg_chk(input string name, input logic [11:0] off, input logic [31:0] exp);
      logic [31:0] rd;
      ahb_xfer(1'b0, off, 32'h0000_0000, rd);
      check(name, rd, exp);
   endtask

   // Event levels on the given pins, then time for status and irq to settle
   task automatic pin_event(input logic [11:0] m);
      ev_req <= m;
      @(posedge sys_clk);
      ev_req <= 12'h000;
      repeat (6) @(posedge sys_clk);
   endtask

   task automatic t_reset();
      reg_chk("status enable", `GPL_OFF_INTSE, 32'h0000_0000);
      reg_chk("led config", `GPL_OFF_LED, 32'h0000_025a);
      check("led select pins", {24'h0, pin_led_sel}, 32'h0000_005a);
   endtask

   task automatic t_reserved();
      reg_wr(`GPL_OFF_INTSE, 32'hffff_ffff);
      reg_chk("status enable", `GPL_OFF_INTSE, 32'h0fff_0000);
      reg_wr(`GPL_OFF_LED, 32'hffff_ffff);
      reg_chk("led config", `GPL_OFF_LED, 32'h0000_03ff);
      reg_chk("unmapped", 12'h100, 32'h0000_0000);
   endtask

   task automatic t_capture();
      reg_wr(`GPL_OFF_INTSE, 32'h0000_0000);
      pin_event(12'h809);
      reg_chk("status enable", `GPL_OFF_INTSE, 32'h0000_0809);
      check("host irq", {31'h0, host_irq}, 32'h0000_0000);
      reg_wr(`GPL_OFF_INTSE, 32'h0000_0800);
      reg_chk("status enable", `GPL_OFF_INTSE, 32'h0000_0009);
      reg_wr(`GPL_OFF_INTSE, 32'h0000_0009);
      reg_chk("status enable", `GPL_OFF_INTSE, 32'h0000_0000);
      // Clear lands while the pin level is still qualified: the event must win
      ev_req <= 12'h004;
      @(posedge sys_clk);
      ev_req <= 12'h000;
      reg_wr(`GPL_OFF_INTSE, 32'h0000_0004);
      reg_chk("status enable", `GPL_OFF_INTSE, 32'h0000_0004);
      reg_wr(`GPL_OFF_INTSE, 32'h0000_0004);
      reg_chk("status enable", `GPL_OFF_INTSE, 32'h0000_0000);
   endtask

   task automatic t_cascade();
      reg_wr(`GPL_OFF_TOP_EN, 32'h0000_1000);
      reg_wr(`GPL_OFF_INTSE, 32'h0001_0000);
      pin_event(12'h010);
      reg_chk("top status", `GPL_OFF_TOP_STS, 32'h0000_0000);
      check("host irq", {31'h0, host_irq}, 32'h0000_0000);
      pin_event(12'h001);
      reg_chk("top status", `GPL_OFF_TOP_STS, 32'h0000_1000);
      check("host irq", {31'h0, host_irq}, 32'h0000_0001);
      reg_wr(`GPL_OFF_TOP_EN, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      check("host irq", {31'h0, host_irq}, 32'h0000_0000);
      reg_chk("top status", `GPL_OFF_TOP_STS, 32'h0000_1000);
      reg_wr(`GPL_OFF_TOP_EN, 32'h0000_1000);
      reg_wr(`GPL_OFF_INTSE, 32'h0001_0011);
      repeat (2) @(posedge sys_clk);
      check("host irq", {31'h0, host_irq}, 32'h0000_0000);
      reg_chk("status enable", `GPL_OFF_INTSE, 32'h0001_0000);
   endtask

   task automatic t_led();
      reg_wr(`GPL_OFF_LED, 32'h0000_010f);
      repeat (2) @(posedge sys_clk);
      check("led select pins", {24'h0, pin_led_sel}, 32'h0000_000f);
      check("led function", {30'h0, led_func}, 32'h0000_0001);
      check("pin drive", {24'h0, pin_out}, 32'h0000_0035);
      reg_wr(`GPL_OFF_LED, 32'h0000_0300);
      repeat (2) @(posedge sys_clk);
      check("pin drive", {24'h0, pin_out}, 32'h0000_003c);
   endtask

   task automatic t_loader();
      eep_ld_func  <= 2'h3;
      eep_ld_sel   <= 8'hc3;
      eep_ld_valid <= 1'b1;
      @(posedge sys_clk);
      eep_ld_valid <= 1'b0;
      @(posedge sys_clk);
      reg_chk("led config", `GPL_OFF_LED, 32'h0000_03c3);
   endtask

   task automatic t_restrap();
      external_reset_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      external_reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reg_chk("led config", `GPL_OFF_LED, 32'h0000_025a);
   endtask

   // Verdict and end of run
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_reserved();
      t_capture();
      t_cascade();
      t_led();
      t_loader();
      t_restrap();
      close_out();
   end

   // Watchdog, far beyond the roughly 140 cycles the tests need
   initial begin
      repeat (3000) @(posedge sys_clk);
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire
